// [hdl/data_input_port.sv]
/*
  Sampling side of the parallel input data port with forwarded clock and frame sync.
  Assumes bus inputs and select pins are synchronous to i_mclk and the source keeps its timing.
*/
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
`include "dip_params.svh"

module data_input_port #(
  parameter int BUS_W = `DIP_BUS_W
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_sel_ctrl,
  input wire logic i_sel_bus,
  input wire logic [BUS_W-1:0] i_bus_data,
  input wire logic [`DIP_ADDR_W-1:0] i_addr,
  input wire logic [`DIP_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`DIP_DATA_W-1:0] o_rdata,
  output logic o_forwarded_data_clock,
  output logic o_frame_sync,
  output dip_pkg::capture_t o_capture,
  output logic o_capture_valid
);

  dip_pkg::if_mode_t mode_q;
  logic inv_q;
  logic [2:0] div_q;
  logic [3:0] phase_sel_q;
  logic [1:0] width_q;
  logic [2:0] latency_q;
  logic [7:0] if_cycles_q;
  logic [7:0] avail_cycles_q;
  logic [6:0] rt_delay_q;
  logic [7:0] period_q;
  logic [7:0] word_count_q;
  logic tick;
  logic [3:0] phase;
  logic period_start;
  logic sample_rise;
  logic sample_fall;
  logic ddr;
  logic take_rise;
  logic take_fall;
  logic first_period;
  logic budget_ok;
  logic [3:0] fall_point;
  dip_pkg::retimer_t rec;

  function automatic logic [BUS_W-1:0] width_mask(input logic [1:0] w);
    logic [BUS_W-1:0] m;
    m = '0;
    case (w)
      `DIP_WIDTH_4: m = BUS_W'(32'h0000_000f);
      `DIP_WIDTH_8: m = BUS_W'(32'h0000_00ff);
      `DIP_WIDTH_16: m = BUS_W'(32'h0000_ffff);
      default: m = '1;
    endcase
    return m;
  endfunction : width_mask

  function automatic dip_pkg::retimer_t retimer_for(input logic [6:0] d);
    dip_pkg::retimer_t r;
    logic [7:0] sum;
    r = '0;
    sum = 8'(8'(d) + `DIP_RT_LAT_OFFSET);
    r.phase = d[3:0];
    r.lat = sum[6:4];
    case (d[3:0])
      4'h0: r.sync = 4'h7;
      4'h1, 4'h2: r.sync = 4'h8;
      4'h3, 4'h4: r.sync = 4'h9;
      4'h5, 4'h6: r.sync = 4'h2;
      4'h7, 4'h8: r.sync = 4'h3;
      4'h9, 4'ha: r.sync = 4'h4;
      4'hb, 4'hc: r.sync = 4'h5;
      4'hd, 4'he: r.sync = 4'h6;
      default: r.sync = 4'h7;
    endcase
    return r;
  endfunction : retimer_for

  phase_divider u_phase_divider (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_div(div_q),
    .o_tick(tick),
    .o_phase(phase)
  );

  // The select pins are caught once, in the first cycle after reset release.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= dip_pkg::MODE_RESET;
    end else begin
      case (mode_q)
        dip_pkg::MODE_RESET: begin
          if (i_sel_ctrl && i_sel_bus) begin
            mode_q <= dip_pkg::MODE_SINGLE;
          end else if (!i_sel_ctrl && !i_sel_bus) begin
            mode_q <= dip_pkg::MODE_DIFF;
          end else begin
            mode_q <= dip_pkg::MODE_BAD;
          end
        end
        dip_pkg::MODE_SINGLE: mode_q <= dip_pkg::MODE_SINGLE;
        dip_pkg::MODE_DIFF: mode_q <= dip_pkg::MODE_DIFF;
        dip_pkg::MODE_BAD: mode_q <= dip_pkg::MODE_BAD;
        default: mode_q <= dip_pkg::MODE_RESET;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      inv_q <= 1'b0;
      div_q <= `DIP_RST_DIV;
      phase_sel_q <= `DIP_RST_PHASE;
      width_q <= `DIP_RST_WIDTH;
      latency_q <= `DIP_RST_LATENCY;
      if_cycles_q <= `DIP_RST_IF_CYCLES;
      avail_cycles_q <= `DIP_RST_AVAIL_CYCLES;
      rt_delay_q <= `DIP_RST_RT_DELAY;
    end else if (i_wr) begin
      case (i_addr)
        `DIP_REG_CLK_CTRL: inv_q <= i_wdata[`DIP_INV_BIT];
        `DIP_REG_CLK_DIV: div_q <= i_wdata[`DIP_DIV_MSB:`DIP_DIV_LSB];
        `DIP_REG_PHASE: phase_sel_q <= i_wdata[`DIP_PHASE_MSB:`DIP_PHASE_LSB];
        `DIP_REG_BUS_WIDTH: width_q <= i_wdata[1:0];
        `DIP_REG_LATENCY: latency_q <= i_wdata[2:0];
        `DIP_REG_IF_CYCLES: if_cycles_q <= i_wdata;
        `DIP_REG_AVAIL_CYCLES: avail_cycles_q <= i_wdata;
        `DIP_REG_RT_DELAY: begin
          // Delays past the last table entry are held at the last entry.
          if (i_wdata[6:0] > `DIP_RT_DELAY_MAX) begin
            rt_delay_q <= `DIP_RT_DELAY_MAX;
          end else begin
            rt_delay_q <= i_wdata[6:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign rec = retimer_for(rt_delay_q);
  assign budget_ok = ({1'b0, avail_cycles_q} >=
                      9'({1'b0, if_cycles_q} + 9'(latency_q) + `DIP_BUDGET_MARGIN));

  // The divider walks sixteen phases per forwarded period, so one phase is a sixteenth.
  assign period_start = tick && (phase == 4'h0);
  assign fall_point = 4'(phase_sel_q + `DIP_HALF_PHASE);
  assign sample_rise = tick && (phase == phase_sel_q);
  assign sample_fall = tick && (phase == fall_point);
  // Single-ended capture never runs at double rate, so the status bit follows the mode too.
  assign ddr = (mode_q == dip_pkg::MODE_DIFF) && (width_q == `DIP_WIDTH_32);
  assign take_rise = ((mode_q == dip_pkg::MODE_SINGLE) && sample_rise) ||
                     ((mode_q == dip_pkg::MODE_DIFF) && ddr && sample_rise);
  assign take_fall = (mode_q == dip_pkg::MODE_DIFF) && sample_fall;
  assign first_period = (period_q == 8'(latency_q));

  // The clock leaves from a flop, one converter cycle behind the phase count.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_forwarded_data_clock <= 1'b0;
    end else if (mode_q == dip_pkg::MODE_BAD || mode_q == dip_pkg::MODE_RESET) begin
      o_forwarded_data_clock <= 1'b0;
    end else begin
      o_forwarded_data_clock <= (~phase[3]) ^ inv_q;
    end
  end

  // Forwarded periods are counted from each frame sync; the sync is high for one period.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      period_q <= 8'h00;
      o_frame_sync <= 1'b0;
    end else if (period_start) begin
      if (period_q >= 8'(avail_cycles_q - 8'h01)) begin
        period_q <= 8'h00;
        o_frame_sync <= 1'b1;
      end else begin
        period_q <= 8'(period_q + 8'h01);
        o_frame_sync <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_capture <= '0;
      o_capture_valid <= 1'b0;
    end else begin
      o_capture_valid <= take_rise || take_fall;
      if (take_rise || take_fall) begin
        o_capture.data <= i_bus_data & width_mask(width_q);
        o_capture.falling <= take_fall;
        // In double rate the rising word of the latency period opens the frame.
        o_capture.first <= first_period && (take_rise || !ddr);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_count_q <= 8'h00;
    end else if (take_rise || take_fall) begin
      word_count_q <= 8'(word_count_q + 8'h01);
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `DIP_REG_CLK_CTRL: o_rdata <= 8'({inv_q, 4'h0});
        `DIP_REG_CLK_DIV: o_rdata <= 8'({div_q, 4'h0});
        `DIP_REG_PHASE: o_rdata <= {phase_sel_q, 4'h0};
        `DIP_REG_BUS_WIDTH: o_rdata <= 8'(width_q);
        `DIP_REG_LATENCY: o_rdata <= 8'(latency_q);
        `DIP_REG_IF_CYCLES: o_rdata <= if_cycles_q;
        `DIP_REG_AVAIL_CYCLES: o_rdata <= avail_cycles_q;
        `DIP_REG_RT_DELAY: o_rdata <= 8'(rt_delay_q);
        `DIP_REG_RT_LAT_SYNC: o_rdata <= {1'b0, rec.lat, rec.sync};
        `DIP_REG_RT_PHASE: o_rdata <= 8'(rec.phase);
        `DIP_REG_STATUS: o_rdata <= 8'({ddr, budget_ok, mode_q});
        `DIP_REG_WORD_COUNT: o_rdata <= word_count_q;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule : data_input_port

// [pkg/dip_params.svh]
/*
  Offsets, field positions, reset values and timing counts of the data input port.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef DIP_PARAMS_SVH
`define DIP_PARAMS_SVH

`define DIP_ADDR_W 8
`define DIP_DATA_W 8
`define DIP_BUS_W 32

`define DIP_REG_CLK_CTRL 8'h20
`define DIP_REG_CLK_DIV 8'h22
`define DIP_REG_PHASE 8'h23
`define DIP_REG_BUS_WIDTH 8'h24
`define DIP_REG_LATENCY 8'h25
`define DIP_REG_IF_CYCLES 8'h26
`define DIP_REG_AVAIL_CYCLES 8'h27
`define DIP_REG_RT_DELAY 8'h28
`define DIP_REG_RT_LAT_SYNC 8'h29
`define DIP_REG_RT_PHASE 8'h2a
`define DIP_REG_STATUS 8'h2b
`define DIP_REG_WORD_COUNT 8'h2c

`define DIP_INV_BIT 4
`define DIP_DIV_LSB 4
`define DIP_DIV_MSB 6
`define DIP_PHASE_LSB 4
`define DIP_PHASE_MSB 7

`define DIP_RST_DIV 3'h1
`define DIP_RST_PHASE 4'h0
`define DIP_RST_WIDTH 2'h3
`define DIP_RST_LATENCY 3'h0
`define DIP_RST_IF_CYCLES 8'h10
`define DIP_RST_AVAIL_CYCLES 8'h20
`define DIP_RST_RT_DELAY 7'h00

`define DIP_PHASES 5'h10
`define DIP_HALF_PHASE 4'h8
`define DIP_LAST_PHASE 4'hf
`define DIP_BUDGET_MARGIN 9'h002
`define DIP_RT_LAT_OFFSET 8'h0a
`define DIP_RT_DELAY_MAX 7'h75

`define DIP_WIDTH_4 2'h0
`define DIP_WIDTH_8 2'h1
`define DIP_WIDTH_16 2'h2
`define DIP_WIDTH_32 2'h3

`endif

// [pkg/dip_pkg.sv]
/*
  Types shared by the data input port modules.
  Assumes dip_params.svh is reachable on the include path.
*/
`include "dip_params.svh"

package dip_pkg;

  typedef enum logic [3:0] {
    MODE_RESET = 4'h1,
    MODE_SINGLE = 4'h2,
    MODE_DIFF = 4'h4,
    MODE_BAD = 4'h8
  } if_mode_t;

  typedef struct packed {
    logic [`DIP_BUS_W-1:0] data;
    logic falling;
    logic first;
  } capture_t;

  typedef struct packed {
    logic [2:0] lat;
    logic [3:0] sync;
    logic [3:0] phase;
  } retimer_t;

endpackage : dip_pkg

// [hdl/phase_divider.sv]
/*
  Divides the converter clock into sixteen phase steps of the forwarded clock period.
  Assumes one clock and a divider value that software may change at any time.
*/
`timescale 1ns/100ps
`include "dip_params.svh"

module phase_divider (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [2:0] i_div,
  output logic o_tick,
  output logic [3:0] o_phase
);

  logic [2:0] pre_q;
  logic [2:0] limit;
  logic step;

  // A zero divider would stall the port, so it is run as a divide by one.
  assign limit = (i_div == 3'h0) ? 3'h0 : 3'(i_div - 3'h1);
  assign step = (pre_q >= limit);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_q <= 3'h0;
    end else if (step) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= 3'(pre_q + 3'h1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_phase <= 4'h0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= step;
      if (step) begin
        o_phase <= 4'(o_phase + 4'h1);
      end
    end
  end

endmodule : phase_divider

// [testbench/dip_sva.sv]
/*
  Port checker for the data input port, bound to its top module.
  Assumes timing checks count only while the divider is one and no invert is set.
*/
`timescale 1ns/100ps
module dip_sva (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_sel_ctrl,
  input wire logic i_sel_bus,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_forwarded_data_clock,
  input wire dip_pkg::capture_t o_capture,
  input wire logic o_capture_valid
);
  logic up_q, sgl_q, dif_q, bad_q, prev_q, slow_q;
  logic [3:0] cnt_q, ph_q;
  logic [4:0] run_q;
  logic [1:0] wid_q;
  logic [5:0] quiet_q;
  logic ok;
  assign ok = quiet_q[5] && up_q && !bad_q && !slow_q;
  // Any write restarts the quiet count, so no check judges a half-applied setting.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      up_q <= 1'b0;
      sgl_q <= 1'b0;
      dif_q <= 1'b0;
      bad_q <= 1'b0;
      prev_q <= 1'b0;
      slow_q <= 1'b0;
      cnt_q <= 4'h0;
      run_q <= 5'h00;
      ph_q <= 4'h0;
      wid_q <= 2'h3;
      quiet_q <= 6'h00;
    end else begin
      if (!up_q) begin
        up_q <= 1'b1;
        sgl_q <= i_sel_ctrl & i_sel_bus;
        dif_q <= ~(i_sel_ctrl | i_sel_bus);
        bad_q <= i_sel_ctrl ^ i_sel_bus;
      end
      prev_q <= o_forwarded_data_clock;
      cnt_q <= (o_forwarded_data_clock && !prev_q) ? 4'h1 : cnt_q + 4'h1;
      run_q <= (o_forwarded_data_clock != prev_q) ? 5'h01 : run_q + 5'h01;
      quiet_q <= i_wr ? 6'h00 : quiet_q + {5'h00, !quiet_q[5]};
      if (i_wr && (i_addr == 8'h22 || i_addr == 8'h20)) slow_q <= 1'b1;
      if (i_wr && i_addr == 8'h23) ph_q <= i_wdata[7:4];
      if (i_wr && i_addr == 8'h24) wid_q <= i_wdata[1:0];
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  bad_quiet_a: assert property (bad_q |-> !o_forwarded_data_clock && !o_capture_valid)
    else $error("clock or capture with mixed straps");
  clock_half_a: assert property (ok && $changed(o_forwarded_data_clock) |-> run_q == 5'h08)
    else $error("forwarded clock half period not eight");
  capture_point_a: assert property (
    o_capture_valid && ok |-> cnt_q == ph_q + {o_capture.falling, 3'h0})
    else $error("capture point off the sample phase");
  rise_only_a: assert property (o_capture_valid && sgl_q |-> !o_capture.falling)
    else $error("single ended falling capture");
  ddr_pair_a: assert property (
    o_capture_valid && dif_q && !o_capture.falling && ok
    |-> ##8 (!ok || o_capture_valid && o_capture.falling))
    else $error("double rate word without its pair");
  sdr_falling_a: assert property (
    o_capture_valid && dif_q && ok |-> o_capture.falling || wid_q == 2'h3)
    else $error("rising capture below full width");
  valid_pulse_a: assert property (o_capture_valid && ok |=> !o_capture_valid)
    else $error("capture valid longer than one cycle");
  capture_hold_a: assert property (!o_capture_valid |-> $stable(o_capture))
    else $error("capture changed without valid");
endmodule : dip_sva

bind data_input_port dip_sva chk (.i_mclk, .i_reset_n, .i_sel_ctrl, .i_sel_bus, .i_addr,
  .i_wdata, .i_wr, .o_forwarded_data_clock, .o_capture, .o_capture_valid);

// [testbench/dip_source.sv]
/*
  Data source model that launches words on the forwarded clock.
  Assumes the bench arms it and reads its queue of launched words.
*/
`timescale 1ns/100ps
module dip_source (
  input wire logic i_mclk,
  input wire logic i_fwd,
  input wire logic i_ddr,
  input wire logic i_arm,
  input wire logic [31:0] i_mask,
  output logic [31:0] o_data
);
  logic [31:0] exp_q[$];
  logic [31:0] w;
  logic prev = 1'b0;
  logic started = 1'b0;
  logic live = 1'b0;
  integer seed = 32'h9a5b;
  initial o_data = 32'h0;
  // Arming waits for a launch, so no word older than the queue is ever judged.
  always @(posedge i_mclk) begin
    prev <= i_fwd;
    live <= started && i_arm;
    if (!i_arm) begin
      started <= 1'b0;
      exp_q.delete();
    end
    if (i_fwd != prev && (i_fwd || i_ddr)) begin
      w = $random(seed);
      o_data <= w;
      if (i_arm) begin
        started <= 1'b1;
        exp_q.push_back(w & i_mask);
      end
    end
  end
endmodule : dip_source

// [testbench/data_input_port_tb_top.sv]
/*
  Self-checking bench for the data input port with a modelled data source.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/100ps
module data_input_port_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sc = 1'b1;
  logic sb = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_d = 1'b0;
  logic arm = 1'b0;
  logic ddr = 1'b0;
  logic [31:0] mask = 32'hffffffff;
  logic [31:0] bus;
  logic [7:0] rdat;
  logic fwd, fs, cap_v;
  dip_pkg::capture_t cap;
  logic [7:0] rd_q[$];
  logic [3:0] sy[16] = '{7, 8, 8, 9, 9, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6, 7};
  int dl[8] = '{0, 5, 6, 21, 22, 101, 117, 127};
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int d;
  time t0;
  logic [7:0] per = 8'h00;
  logic per_ok = 1'b0;
  logic fwd_d = 1'b0;
  logic [2:0] lat = 3'h0;
  always #50 clk = ~clk;
  data_input_port dut (.i_mclk(clk), .i_reset_n(rst_n), .i_sel_ctrl(sc), .i_sel_bus(sb),
    .i_bus_data(bus), .i_addr(addr), .i_wdata(wdat), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdat), .o_forwarded_data_clock(fwd), .o_frame_sync(fs), .o_capture(cap),
    .o_capture_valid(cap_v));
  dip_source src (.i_mclk(clk), .i_fwd(fwd), .i_ddr(ddr), .i_arm(arm), .i_mask(mask),
    .o_data(bus));
  task stop_test;
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    if (a == 8'h25) lat <= v[2:0];
    addr <= a;
    wdat <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic rst(input logic c, input logic b);
    sc <= c;
    sb <= b;
    arm <= 1'b0;
    lat <= 3'h0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : rst
  // Six forwarded periods give several words per setting without a long run.
  task automatic run(input logic [3:0] ph, input logic [1:0] w, input logic dr);
    wr(8'h23, {ph, 4'h0});
    wr(8'h24, {6'h00, w});
    mask <= 32'((64'h1 << (4 << w)) - 64'h1);
    ddr <= dr;
    arm <= 1'b1;
    repeat (96) @(posedge clk);
    arm <= 1'b0;
    @(posedge clk);
  endtask : run
  always @(posedge clk) begin
    rd_d <= rd_s;
    fwd_d <= fwd;
    // Periods are counted from the frame sync; an invert change adds a false edge.
    if (!rst_n || (wr_s && addr == 8'h20)) begin
      per_ok <= 1'b0;
    end else if (fwd && !fwd_d) begin
      per <= fs ? 8'h00 : 8'(per + 8'h01);
      per_ok <= per_ok || fs;
    end
    cyc++;
    if (cyc == 6000) begin
      failures++;
      stop_test();
    end
  end
  always @(negedge clk) begin
    if (rd_d) chk("rdata", 32'(rdat), 32'(rd_q.pop_front()));
    if (src.live && cap_v === 1'b1) chk("word", cap.data, src.exp_q.pop_front());
    if (per_ok && cap_v === 1'b1)
      chk("first", 32'(cap.first), 32'(per == 8'(lat) && !(ddr && cap.falling)));
  end
  initial begin
    rst(1'b1, 1'b1);
    rd(8'h22, 8'h10);
    rd(8'h23, 8'h00);
    rd(8'h24, 8'h03);
    rd(8'h27, 8'h20);
    rd(8'h00, 8'h00);
    rd(8'h2b, 8'h12);
    foreach (dl[i]) begin
      d = dl[i] > 117 ? 117 : dl[i];
      wr(8'h28, 8'(dl[i]));
      rd(8'h29, {1'b0, 3'((d + 10) / 16), sy[d % 16]});
      rd(8'h2a, 8'(d % 16));
    end
    wr(8'h27, 8'h12);
    wr(8'h25, 8'h01);
    rd(8'h2b, 8'h02);
    wr(8'h27, 8'h13);
    rd(8'h2b, 8'h12);
    @(posedge fs);
    @(posedge fs);
    t0 = $time;
    @(negedge fs);
    chk("sync high", 32'(($time - t0) / 100), 32'd16);
    @(posedge fs);
    chk("sync period", 32'(($time - t0) / 100), 32'd304);
    run(4'h0, 2'h3, 1'b0);
    run(4'h9, 2'h0, 1'b0);
    run(4'hf, 2'h1, 1'b0);
    wr(8'h22, 8'h20);
    @(posedge fwd);
    @(posedge fwd);
    t0 = $time;
    @(posedge fwd);
    chk("clock period", 32'(($time - t0) / 100), 32'd32);
    wr(8'h20, 8'h10);
    rd(8'h20, 8'h10);
    @(posedge fs);
    @(negedge clk);
    chk("clock invert", 32'(fwd), 32'h0);
    rst(1'b0, 1'b0);
    rd(8'h2b, 8'h34);
    run(4'h3, 2'h3, 1'b1);
    wr(8'h24, 8'h02);
    rd(8'h2b, 8'h14);
    run(4'h5, 2'h2, 1'b0);
    rst(1'b1, 1'b0);
    repeat (40) @(posedge clk);
    rd(8'h2b, 8'h18);
    rd(8'h2c, 8'h00);
    stop_test();
  end
endmodule : data_input_port_tb_top
